// [hw/mbs_pkg.sv]
// Constants, types and register map of the mechanical brake sequencer.
package mbs_pkg;

   // Clock and setting time base.
   localparam int CLK_PERIOD_NS = 10;
   localparam int TIME_UNIT_NS  = 10_000_000;
   localparam int TICK_CYCLES   = TIME_UNIT_NS / CLK_PERIOD_NS;

   // Widths and counts.
   localparam int AW   = 8;
   localparam int DW   = 32;
   localparam int FW   = 16;
   localparam int TW   = 16;
   localparam int NIN  = 8;
   localparam int NOUT = 5;
   localparam int IFW  = 8;
   localparam int OFW  = 6;
   localparam int SELW = 2;
   localparam int IRQW = 4;

   // Register byte addresses.
   localparam logic [AW-1:0] A_CTRL     = 8'h00;
   localparam logic [AW-1:0] A_SETTLE   = 8'h04;
   localparam logic [AW-1:0] A_ACCHOLD  = 8'h08;
   localparam logic [AW-1:0] A_STPHOLD  = 8'h0C;
   localparam logic [AW-1:0] A_CONFTO   = 8'h10;
   localparam logic [AW-1:0] A_RELFREQ  = 8'h14;
   localparam logic [AW-1:0] A_RELCUR   = 8'h18;
   localparam logic [AW-1:0] A_INFN_LO  = 8'h1C;
   localparam logic [AW-1:0] A_INFN_HI  = 8'h20;
   localparam logic [AW-1:0] A_OUTFN    = 8'h24;
   localparam logic [AW-1:0] A_STATUS   = 8'h28;
   localparam logic [AW-1:0] A_IRQ_STAT = 8'h2C;
   localparam logic [AW-1:0] A_IRQ_EN   = 8'h30;
   localparam logic [AW-1:0] A_IRQ_CLR  = 8'h34;

   // Codes and field values.
   localparam logic [SELW-1:0] SEL_ENABLED = 2'h1;
   localparam logic [IFW-1:0]  FN_CONFIRM  = 8'h2C;
   localparam logic [OFW-1:0]  FN_RELEASE  = 6'h13;
   localparam logic [OFW-1:0]  FN_FAULT    = 6'h14;
   localparam logic [FW-1:0]   FREQ_ZERO   = 16'h0000;

   // Interrupt bit positions.
   localparam int IRQ_REL_ON  = 0;
   localparam int IRQ_REL_OFF = 1;
   localparam int IRQ_FAULT   = 2;
   localparam int IRQ_STOPPED = 3;

   typedef enum logic [10:0] {
      ST_IDLE     = 11'h001,
      ST_ACCEL    = 11'h002,
      ST_SETTLE   = 11'h004,
      ST_CONF_ON  = 11'h008,
      ST_ACC_HOLD = 11'h010,
      ST_RUN      = 11'h020,
      ST_DEC_REL  = 11'h040,
      ST_CONF_OFF = 11'h080,
      ST_STP_HOLD = 11'h100,
      ST_DEC_ZERO = 11'h200,
      ST_FAULT    = 11'h400
   } mbs_state_e;

   typedef struct packed {
      logic          out_enable;
      logic [FW-1:0] freq_target;
   } mbs_drv_s;

   typedef struct packed {
      logic [SELW-1:0]          select;
      logic [TW-1:0]            settle;
      logic [TW-1:0]            acc_hold;
      logic [TW-1:0]            stp_hold;
      logic [TW-1:0]            conf_to;
      logic [FW-1:0]            rel_freq;
      logic [FW-1:0]            rel_cur;
      logic [NIN-1:0][IFW-1:0]  in_fn;
      logic [NOUT-1:0][OFW-1:0] out_fn;
   } mbs_cfg_s;

endpackage

// [hw/mbs_top.sv]
// Brake sequencer that sits beside the drive's frequency ramp.
`timescale 1ns/1ps

// What this block does
// - Sequence only when selection equals 01.
// - On run, ramp to release frequency, hold.
// - At release frequency, wait settle, then release.
// - Low current after settle: trip, fault.
// - Confirm assigned: wait confirm high or trip.
// - Confirm unassigned: go straight to acceleration hold.
// - Wait acceleration hold, then ramp to command.
// - Run removed: ramp to release frequency, close.
// - Confirm assigned: wait confirm low or trip.
// - Confirm unassigned: go straight to stop hold.
// - Wait stop hold, then ramp to zero.
// - Route release code 19, fault code 20.
// - Confirm dropping while released trips with fault.
module mbs_top
   import mbs_pkg::*;
#(
   parameter int TICKS = mbs_pkg::TICK_CYCLES,
   parameter int NI    = mbs_pkg::NIN,
   parameter int NO    = mbs_pkg::NOUT
)(
   input  wire logic                 clock,
   input  wire logic                 sys_rst,
   input  wire logic                 clk_en,
   input  wire logic                 run_cmd,
   input  wire logic                 drive_reset,
   input  wire logic [mbs_pkg::FW-1:0] cmd_freq,
   input  wire logic [mbs_pkg::FW-1:0] out_freq,
   input  wire logic [mbs_pkg::FW-1:0] out_current,
   input  wire logic [NI-1:0]        in_pins,
   input  wire logic [mbs_pkg::AW-1:0] addr,
   input  wire logic [mbs_pkg::DW-1:0] wr_data,
   input  wire logic                 wr_en,
   input  wire logic                 rd_en,
   output mbs_pkg::mbs_drv_s         drive_out,
   output logic                      brake_release_out,
   output logic                      brake_fault_out,
   output logic [NO-1:0]             mf_out,
   output logic [mbs_pkg::DW-1:0]    rd_data,
   output logic                      irq
);
   import mbs_pkg::*;

   mbs_cfg_s        cfg_q;
   mbs_state_e      state_q;
   mbs_state_e      state_d;
   mbs_drv_s        drv_q;
   logic            rel_q;
   logic            flt_q;
   logic [NO-1:0]   mf_q;
   logic [DW-1:0]   rd_q;
   logic [IRQW-1:0] ist_q;
   logic [IRQW-1:0] ien_q;
   logic [IRQW-1:0] ev;
   logic [IRQW-1:0] iclr;
   logic [31:0]     presc_q;
   logic            tick;
   logic [TW-1:0]   tmr_q;
   logic [TW-1:0]   limit;
   logic            done;
   logic            brk_en;
   logic [NI-1:0]   conf_match;
   logic [NI-1:0]   conf_vec;
   logic            conf_asg;
   logic            conf_in;
   logic            conf_drop;
   logic            rel_d;
   logic            flt_d;

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cfg_q <= '0;
      end
      else if (clk_en && wr_en)
      begin
         if (addr == A_CTRL)
            cfg_q.select <= wr_data[SELW-1:0];
         else if (addr == A_SETTLE)
            cfg_q.settle <= wr_data[TW-1:0];
         else if (addr == A_ACCHOLD)
            cfg_q.acc_hold <= wr_data[TW-1:0];
         else if (addr == A_STPHOLD)
            cfg_q.stp_hold <= wr_data[TW-1:0];
         else if (addr == A_CONFTO)
            cfg_q.conf_to <= wr_data[TW-1:0];
         else if (addr == A_RELFREQ)
            cfg_q.rel_freq <= wr_data[FW-1:0];
         else if (addr == A_RELCUR)
            cfg_q.rel_cur <= wr_data[FW-1:0];
         else if (addr == A_INFN_LO)
            cfg_q.in_fn[3:0] <= wr_data;
         else if (addr == A_INFN_HI)
            cfg_q.in_fn[7:4] <= wr_data;
         else if (addr == A_OUTFN)
            cfg_q.out_fn <= wr_data[NOUT*OFW-1:0];
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   // Read data stands for one cycle only; unmapped addresses read zero.
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         rd_q <= '0;
      else if (clk_en)
      begin
         rd_q <= '0;
         if (rd_en)
         begin
            if (addr == A_CTRL)
               rd_q <= DW'(cfg_q.select);
            else if (addr == A_SETTLE)
               rd_q <= DW'(cfg_q.settle);
            else if (addr == A_ACCHOLD)
               rd_q <= DW'(cfg_q.acc_hold);
            else if (addr == A_STPHOLD)
               rd_q <= DW'(cfg_q.stp_hold);
            else if (addr == A_CONFTO)
               rd_q <= DW'(cfg_q.conf_to);
            else if (addr == A_RELFREQ)
               rd_q <= DW'(cfg_q.rel_freq);
            else if (addr == A_RELCUR)
               rd_q <= DW'(cfg_q.rel_cur);
            else if (addr == A_INFN_LO)
               rd_q <= cfg_q.in_fn[3:0];
            else if (addr == A_INFN_HI)
               rd_q <= cfg_q.in_fn[7:4];
            else if (addr == A_OUTFN)
               rd_q <= DW'(cfg_q.out_fn);
            else if (addr == A_STATUS)
               rd_q <= DW'({conf_in, conf_asg, flt_q, rel_q, state_q});
            else if (addr == A_IRQ_STAT)
               rd_q <= DW'(ist_q);
            else if (addr == A_IRQ_EN)
               rd_q <= DW'(ien_q);
         end
      end
   end

   assign rd_data = rd_q;

   // ****************************************************************
   // Confirm input selection
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < NI; gi++)
      begin : g_conf
         assign conf_match[gi] = (cfg_q.in_fn[gi] == FN_CONFIRM);
         assign conf_vec[gi]   = conf_match[gi] & in_pins[gi];
      end
   endgenerate

   assign conf_asg  = |conf_match;
   assign conf_in   = |conf_vec;
   assign conf_drop = conf_asg && !conf_in;
   assign brk_en    = (cfg_q.select == SEL_ENABLED);

   // ****************************************************************
   // Wait timer
   // ****************************************************************
   // One tick per setting unit; timer restarts on every state change.
   // The prescaler restarts with the timer, so no wait is cut short by a
   // tick that happens to fall just after the state was entered.
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         presc_q <= '0;
      else if (clk_en)
      begin
         if (tick || (state_d != state_q))
            presc_q <= '0;
         else
            presc_q <= presc_q + 32'h1;
      end
   end

   assign tick = (presc_q >= 32'(TICKS - 1));

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         tmr_q <= '0;
      else if (clk_en)
      begin
         if (state_d != state_q)
            tmr_q <= '0;
         else if (tick && (tmr_q != '1))
            tmr_q <= tmr_q + TW'(1);
      end
   end

   always_comb
   begin
      limit = cfg_q.settle;
      if (state_q == ST_CONF_ON || state_q == ST_CONF_OFF)
         limit = cfg_q.conf_to;
      else if (state_q == ST_ACC_HOLD)
         limit = cfg_q.acc_hold;
      else if (state_q == ST_STP_HOLD)
         limit = cfg_q.stp_hold;
   end

   assign done = (tmr_q >= limit);

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb
   begin
      state_d = state_q;
      if (!brk_en)
         state_d = ST_IDLE;
      else
      begin
         case (state_q)
            ST_IDLE:
               if (run_cmd)
                  state_d = ST_ACCEL;
            ST_ACCEL:
               if (!run_cmd)
                  state_d = ST_DEC_ZERO;
               else if (out_freq >= cfg_q.rel_freq)
                  state_d = ST_SETTLE;
            ST_SETTLE:
               if (!run_cmd)
                  state_d = ST_DEC_ZERO;
               else if (done && out_current < cfg_q.rel_cur)
                  state_d = ST_FAULT;
               else if (done)
                  state_d = conf_asg ? ST_CONF_ON : ST_ACC_HOLD;
            ST_CONF_ON:
               if (conf_in)
                  state_d = ST_ACC_HOLD;
               else if (done)
                  state_d = ST_FAULT;
            ST_ACC_HOLD:
               if (conf_drop)
                  state_d = ST_FAULT;
               else if (!run_cmd)
                  state_d = ST_DEC_REL;
               else if (done)
                  state_d = ST_RUN;
            ST_RUN:
               if (conf_drop)
                  state_d = ST_FAULT;
               else if (!run_cmd)
                  state_d = ST_DEC_REL;
            ST_DEC_REL:
               if (conf_drop)
                  state_d = ST_FAULT;
               else if (out_freq <= cfg_q.rel_freq)
                  state_d = conf_asg ? ST_CONF_OFF : ST_STP_HOLD;
            ST_CONF_OFF:
               if (!conf_in)
                  state_d = ST_STP_HOLD;
               else if (done)
                  state_d = ST_FAULT;
            ST_STP_HOLD:
               if (done)
                  state_d = ST_DEC_ZERO;
            ST_DEC_ZERO:
               if (out_freq == FREQ_ZERO)
                  state_d = ST_IDLE;
            ST_FAULT:
               if (drive_reset)
                  state_d = ST_IDLE;
            default:
               state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         state_q <= ST_IDLE;
      else if (clk_en)
         state_q <= state_d;
   end

   // ****************************************************************
   // Drive, brake and terminal outputs
   // ****************************************************************
   // Outputs are computed from the next state so they line up with it.
   assign rel_d = (state_d == ST_CONF_ON) || (state_d == ST_ACC_HOLD) ||
                  (state_d == ST_RUN) || (state_d == ST_DEC_REL);
   assign flt_d = (state_d == ST_FAULT);

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         drv_q <= '0;
         rel_q <= 1'b0;
         flt_q <= 1'b0;
      end
      else if (clk_en)
      begin
         rel_q <= rel_d;
         flt_q <= flt_d;
         drv_q.out_enable <= !(state_d == ST_IDLE || state_d == ST_FAULT);
         if (state_d == ST_RUN)
            drv_q.freq_target <= cmd_freq;
         else if (state_d == ST_IDLE || state_d == ST_FAULT || state_d == ST_DEC_ZERO)
            drv_q.freq_target <= FREQ_ZERO;
         else
            drv_q.freq_target <= cfg_q.rel_freq;
      end
   end

   generate
      for (gi = 0; gi < NO; gi++)
      begin : g_mfo
         always_ff @(posedge clock or posedge sys_rst)
         begin
            if (sys_rst)
               mf_q[gi] <= 1'b0;
            else if (clk_en)
               mf_q[gi] <= (cfg_q.out_fn[gi] == FN_RELEASE && rel_d) ||
                           (cfg_q.out_fn[gi] == FN_FAULT && flt_d);
         end
      end
   endgenerate

   assign drive_out         = drv_q;
   assign brake_release_out = rel_q;
   assign brake_fault_out   = flt_q;
   assign mf_out            = mf_q;

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   // A new event wins over a clear written in the same cycle.
   assign ev[IRQ_REL_ON]  = rel_d && !rel_q;
   assign ev[IRQ_REL_OFF] = !rel_d && rel_q;
   assign ev[IRQ_FAULT]   = flt_d && !flt_q;
   assign ev[IRQ_STOPPED] = (state_q == ST_DEC_ZERO) && (state_d == ST_IDLE);
   assign iclr = (wr_en && addr == A_IRQ_CLR) ? wr_data[IRQW-1:0] : '0;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         ist_q <= '0;
      else if (clk_en)
         ist_q <= (ist_q & ~iclr) | ev;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         ien_q <= '0;
      else if (clk_en && wr_en && addr == A_IRQ_EN)
         ien_q <= wr_data[IRQW-1:0];
   end

   assign irq = |(ist_q & ien_q);

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sel_gate_a: assert property (clk_en && !brk_en |=> !rel_q && !flt_q)
      else $error("Outputs active while sequencing disabled.");
   run_start_a: assert property (clk_en && brk_en && state_q == ST_IDLE && run_cmd
      |=> state_q == ST_ACCEL && drv_q.out_enable && drv_q.freq_target == $past(cfg_q.rel_freq))
      else $error("Run did not start ramp to release frequency.");
   settle_rel_a: assert property ($rose(rel_q) |-> $past(state_q) == ST_SETTLE && $past(done))
      else $error("Release asserted before settle time.");
   low_cur_a: assert property (clk_en && brk_en && run_cmd && state_q == ST_SETTLE && done
      && out_current < cfg_q.rel_cur |=> state_q == ST_FAULT && !rel_q && flt_q)
      else $error("Low current did not trip.");
   conf_on_a: assert property (clk_en && brk_en && state_q == ST_CONF_ON && done && !conf_in
      |=> flt_q)
      else $error("Confirm on timeout not tripped.");
   no_conf_a: assert property ($rose(rel_q) && !$past(conf_asg) |-> state_q == ST_ACC_HOLD)
      else $error("Unassigned confirm did not skip wait.");
   acc_hold_a: assert property ($rose(state_q == ST_RUN) |-> $past(state_q) == ST_ACC_HOLD
      && $past(done))
      else $error("Ramp resumed without acceleration hold.");
   rel_off_a: assert property ($fell(rel_q) && !flt_q && brk_en |-> $past(state_q) == ST_DEC_REL
      && $past(out_freq) <= $past(cfg_q.rel_freq))
      else $error("Release dropped above release frequency.");
   conf_off_a: assert property (clk_en && brk_en && state_q == ST_CONF_OFF && done && conf_in
      |=> flt_q)
      else $error("Confirm off timeout not tripped.");
   skip_off_a: assert property ($fell(rel_q) && !flt_q && brk_en && !$past(conf_asg)
      |-> state_q == ST_STP_HOLD)
      else $error("Unassigned confirm did not skip off wait.");
   zero_ramp_a: assert property (state_q == ST_DEC_ZERO |-> drv_q.freq_target == FREQ_ZERO
      && $past(state_q) inside {ST_DEC_ZERO, ST_STP_HOLD, ST_ACCEL, ST_SETTLE})
      else $error("Ramp to zero without stop hold.");
   conf_drop_a: assert property (clk_en && brk_en && rel_q && conf_drop && state_q != ST_CONF_ON
      |=> state_q == ST_FAULT)
      else $error("Confirm drop while released not tripped.");
   fault_hold_a: assert property (state_q == ST_FAULT && brk_en && !drive_reset
      |=> flt_q && !rel_q && !drv_q.out_enable)
      else $error("Fault released without drive reset.");

   run_reach_c: cover property (state_q == ST_ACC_HOLD ##1 state_q == ST_RUN);
   fault_c:     cover property ($rose(flt_q));
   stop_c:      cover property (state_q == ST_DEC_ZERO ##1 state_q == ST_IDLE);
   conf_c:      cover property (state_q == ST_CONF_OFF ##1 state_q == ST_STP_HOLD);

endmodule

// [bench/mbs_brake_model.sv]
// Behavioural external brake with a confirmation contact.
`timescale 1ns/1ps
module mbs_brake_model (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       release_in,
   input  wire logic [1:0] mode,
   input  wire logic [7:0] delay,
   output logic            confirm_out
);
   // ***********************************
   // Contact behaviour
   // ***********************************
   // Mode 0 follows release after delay plus one cycles, 1 never closes the contact,
   // 2 drops it while still released, 3 never opens it again.
   logic [7:0] cnt_q;
   logic       want;
   logic       drop;
   assign want = (mode == 2'h1) ? 1'b0 :
                 (mode == 2'h3) ? (release_in | confirm_out) : release_in;
   assign drop = (mode == 2'h2) & confirm_out & release_in;
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_q       <= 8'h00;
         confirm_out <= 1'b0;
      end
      else if (want == confirm_out && !drop)
         cnt_q <= 8'h00;
      else if (cnt_q >= delay)
      begin
         confirm_out <= ~confirm_out;
         cnt_q       <= 8'h00;
      end
      else
         cnt_q <= cnt_q + 8'h01;
   end
endmodule

// [bench/tb.sv]
// Self-checking bench for the brake sequencer with a ramp and brake model.
`timescale 1ns/1ps
module tb;
   import mbs_pkg::*;
   // ***********************************
   // Signals and models
   // ***********************************
   localparam int          T    = 4;
   localparam logic [15:0] RELF = 16'h0100;
   localparam logic [15:0] RELC = 16'h0200;
   logic           clock       = 1'b0;
   logic           sys_rst     = 1'b1;
   logic           run_cmd     = 1'b0;
   logic           drive_reset = 1'b0;
   logic           clk_en      = 1'b1;
   logic [FW-1:0]  cmd_freq    = 16'h0000;
   logic [FW-1:0]  out_freq    = 16'h0000;
   logic [FW-1:0]  out_current = 16'h0000;
   logic [NIN-1:0] in_pins     = 8'h00;
   logic [AW-1:0]  addr        = 8'h00;
   logic [DW-1:0]  wr_data     = 32'h0000_0000;
   logic           wr_en       = 1'b0;
   logic           rd_en       = 1'b0;
   logic [1:0]     bmode       = 2'h0;
   logic [7:0]     bdelay      = 8'h02;
   mbs_drv_s       drive_out;
   logic           rel;
   logic           flt;
   logic           irq;
   logic           conf;
   logic [NOUT-1:0] mf_out;
   logic [DW-1:0]  rd_data;
   logic [DW-1:0]  rv;
   logic [FW-1:0]  tgt;
   int             miscompares = 0;
   int             checks_done = 0;
   int             cyc         = 0;
   int             n;

   always #5 clock = ~clock;

   mbs_top #(.TICKS(T)) u_mbs_top (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
      .run_cmd(run_cmd), .drive_reset(drive_reset), .cmd_freq(cmd_freq),
      .out_freq(out_freq), .out_current(out_current), .in_pins(in_pins),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .drive_out(drive_out), .brake_release_out(rel), .brake_fault_out(flt),
      .mf_out(mf_out), .rd_data(rd_data), .irq(irq));

   mbs_brake_model u_mbs_brake_model (.clock(clock), .sys_rst(sys_rst),
      .release_in(rel), .mode(bmode), .delay(bdelay), .confirm_out(conf));

   // The ramp moves in steps so the release frequency is crossed, not jumped.
   assign tgt = drive_out.out_enable ? drive_out.freq_target : FREQ_ZERO;
   always @(posedge clock)
   begin
      cyc++;
      in_pins <= {7'($urandom), conf};
      if (out_freq + 16'h0010 <= tgt)
         out_freq <= out_freq + 16'h0010;
      else if (out_freq >= tgt + 16'h0010)
         out_freq <= out_freq - 16'h0010;
      else
         out_freq <= tgt;
      if (cyc == 40000)
      begin
         miscompares++;
         finish_test();
      end
   end

   // ***********************************
   // Tasks
   // ***********************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask

   function automatic logic hit(input int s);
      case (s)
         0: return out_freq >= RELF;
         1: return rel | flt;
         2: return flt;
         3: return !rel;
         4: return drive_out.freq_target == cmd_freq;
         5: return drive_out.freq_target == FREQ_ZERO;
         default: return out_freq == FREQ_ZERO;
      endcase
   endfunction

   task automatic wait_until(input int s, input int lim);
      n = 0;
      while (hit(s) !== 1'b1 && n < lim)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(32'(n >= lim), 32'h0);
   endtask

   task automatic cycle(input logic asg, input logic [1:0] m, input logic low);
      int d;
      wr(A_INFN_LO, asg ? 32'h0000_002C : 32'h0000_0000);
      wr(A_IRQ_CLR, 32'h0000_000F);
      d = 1 + $urandom % 10;
      bmode <= m;
      bdelay <= 8'(d);
      out_current <= low ? RELC - 16'h0001 : RELC + 16'($urandom % 256);
      cmd_freq <= 16'h0200 + 16'($urandom % 64) * 16'h0010;
      run_cmd <= 1'b1;
      wait_until(0, 400);
      wait_until(1, 400);
      chk(32'(n >= 2 * T && n <= 2 * T + 4), 32'h1);
      if (low)
         chk({rel, flt, mf_out[1:0], drive_out.out_enable}, 32'h0C);
      else
      begin
         chk({rel, flt, mf_out[1:0], drive_out.freq_target}, {4'h9, RELF});
         if (m == 2'h1)
         begin
            wait_until(2, 3 * T + 10);
            chk(32'(n >= 3 * T), 32'h1);
         end
         else if (m == 2'h2)
            wait_until(2, 40);
         else
         begin
            wait_until(4, 400);
            chk(32'(n >= T + (asg ? d : 0) && (asg || n <= T + 4)), 32'h1);
            run_cmd <= 1'b0;
            wait_until(3, 400);
            chk({flt, out_freq <= RELF}, 32'h1);
            if (m == 2'h3)
               wait_until(2, 3 * T + 10);
            else
            begin
               wait_until(5, 200);
               chk(32'(n >= T + (asg ? d : 0) && flt === 1'b0), 32'h1);
               wait_until(6, 400);
               repeat (3) @(posedge clock);
               rd(A_STATUS, rv);
               chk(rv, {18'h0, asg, 13'h0001});
               rd(A_IRQ_STAT, rv);
               chk(rv, 32'h0000_000B);
            end
         end
      end
      if (flt === 1'b1)
      begin
         run_cmd <= 1'b0;
         repeat (20) @(posedge clock);
         #1;
         chk({flt, rel, drive_out.out_enable, mf_out[1:0], irq}, 32'h25);
         wr(A_IRQ_EN, 32'h0);
         #1;
         chk(irq, 1'b0);
         wr(A_IRQ_EN, 32'h4);
         wr(A_IRQ_CLR, 32'h4);
         #1;
         chk({flt, irq}, 32'h2);
         drive_reset <= 1'b1;
         wr(A_IRQ_EN, 32'h4);
         drive_reset <= 1'b0;
         wait_until(6, 400);
         chk(flt, 1'b0);
      end
      $display("test done asg=%0d mode=%0d low=%0d", asg, m, low);
   endtask

   task automatic finish_test;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ***********************************
   // Main sequence
   // ***********************************
   initial
   begin
      void'($urandom(13912));
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      for (int a = 0; a <= 8'h3C; a += 4)
      begin
         rd(8'(a), rv);
         chk(rv, (a == 8'h28) ? 32'h1 : 32'h0);
      end
      wr(A_SETTLE, 32'h2);
      wr(A_ACCHOLD, 32'h1);
      wr(A_STPHOLD, 32'h1);
      wr(A_CONFTO, 32'h3);
      wr(A_RELFREQ, {16'h0, RELF});
      wr(A_RELCUR, {16'h0, RELC});
      wr(A_OUTFN, 32'h0000_0513);
      wr(A_IRQ_EN, 32'h4);
      clk_en <= 1'b0;
      wr(A_RELFREQ, 32'h0);
      clk_en <= 1'b1;
      rd(A_RELFREQ, rv);
      chk(rv, {16'h0, RELF});
      for (int s = 0; s < 4; s += (s == 0) ? 2 : 1)
      begin
         wr(A_CTRL, 32'(s));
         run_cmd <= 1'b1;
         repeat (60) @(posedge clock);
         #1;
         chk({rel, flt, mf_out}, 32'h0);
         run_cmd <= 1'b0;
      end
      wr(A_CTRL, 32'h1);
      $display("test done select");
      cycle(1'b0, 2'h0, 1'b0);
      cycle(1'b1, 2'h0, 1'b0);
      cycle(1'b0, 2'h0, 1'b1);
      cycle(1'b1, 2'h1, 1'b0);
      cycle(1'b1, 2'h2, 1'b0);
      cycle(1'b1, 2'h3, 1'b0);
      repeat (6) cycle(1'($urandom), 2'h0, 1'b0);
      finish_test();
   end
endmodule
